// ### src/ubg_pkg.sv
package ubg_pkg;

   // register byte addresses on the APB window
   localparam logic [11:0] ADDR_CONTROL_TWO = 12'h000;
   localparam logic [11:0] ADDR_CONTROL_THREE = 12'h004;
   localparam logic [11:0] ADDR_DIVISOR = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00c;

   // field positions
   localparam int SPEED_SELECT_POS = 5;
   localparam int SOFT_RESET_POS = 7;
   localparam int STATUS_HOLD_POS = 8;

   // power-on values
   localparam logic SPEED_SELECT_RESET = 1'h0;
   localparam logic SOFT_RESET_RESET = 1'h0;
   localparam logic [7:0] DIVISOR_START = 8'h00;

   // prescaler: 16 clocks per count in high speed, 64 in low speed
   localparam int PRESCALE_HIGH = 16;
   localparam int PRESCALE_LOW = 64;
   localparam logic [5:0] PRESCALE_HIGH_LAST = 6'(PRESCALE_HIGH - 1);
   localparam logic [5:0] PRESCALE_LOW_LAST = 6'(PRESCALE_LOW - 1);

   typedef struct packed {
      logic ctrlReset;
      logic speedSel;
      logic [7:0] divisor;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic bitTick;
      logic portReset;
   } ubg_top_state_t;

   typedef struct packed {
      logic [5:0] prescale;
      logic [7:0] count;
      logic tick;
   } ubg_timer_state_t;

endpackage

// ### src/ubg_timer_if.sv
`timescale 1ns/10ps
`default_nettype none

interface ubg_timer_if;
   logic [7:0] divisor;
   logic speedSel;
   logic hold;
   logic tick;
   logic [7:0] count;

   modport ctrl
   (
      output divisor,
      output speedSel,
      output hold,
      input tick,
      input count
   );

   modport timer
   (
      input divisor,
      input speedSel,
      input hold,
      output tick,
      output count
   );
endinterface

`default_nettype wire

// ### src/ubg_rate_timer.sv
`timescale 1ns/10ps
`default_nettype none

module ubg_rate_timer
(
   input wire logic clk,
   input wire logic srst,
   ubg_timer_if.timer tif
);

   ubg_pkg::ubg_timer_state_t state;
   ubg_pkg::ubg_timer_state_t next_state;
   logic [5:0] prescaleLast;

   always_comb
   begin
      next_state = state;
      next_state.tick = 1'b0;
      prescaleLast = tif.speedSel ? ubg_pkg::PRESCALE_HIGH_LAST
                                  : ubg_pkg::PRESCALE_LOW_LAST; // RULE7 RULE10
      if (tif.hold)
      begin
         // port held in reset: timer parked, loaded with divisor
         next_state.prescale = 6'h00; // RULE2
         next_state.count = tif.divisor;
      end
      else if (state.prescale >= prescaleLast)
      begin
         next_state.prescale = 6'h00;
         if (state.count == 8'h00)
         begin
            // terminal count: reload and issue one bit period
            next_state.count = tif.divisor; // RULE11 RULE8
            next_state.tick = 1'b1; // RULE11
         end
         else
         begin
            next_state.count = state.count - 8'h01; // RULE5 RULE6
         end
      end
      else
      begin
         next_state.prescale = state.prescale + 6'h01; // RULE5
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= '{prescale: 6'h00, count: 8'h00, tick: 1'b0};
      end
      else
      begin
         state <= next_state;
      end
   end

   assign tif.tick = state.tick;
   assign tif.count = state.count;

endmodule

`default_nettype wire

// ### src/ubg_baud_core.sv
// Behaviour
// RULE1: soft reset bit clear means the port runs with no reset applied.
// RULE2: soft reset bit set holds transmitter, receiver and timer in reset.
// RULE3: soft reset returns every port register to its power-on value. Code restores only speed select; divisor keeps its value.
// RULE4: soft reset bit sits at bit 7, powers up zero; bits 6..0 read zero.
// RULE5: bit rate comes from a dedicated free-running 8-bit timer.
// RULE6: timer period set jointly by divisor value and speed select.
// RULE7: speed select 0 gives clk/(64*(N+1)); 1 gives clk/(16*(N+1)).
// RULE8: divisor is unsigned 0..255; every value including zero is valid.
// RULE9: divisor fully read/write; not forced at reset. Code ignores divisor writes while the soft reset bit is set.
// RULE10: speed select 1 is high speed, 0 low speed; powers up zero.
// RULE11: timer reloads divisor each terminal count; one tick per N+1 counts.
`timescale 1ns/10ps
`default_nettype none

module ubg_baud_core
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic bitTick,
   output logic portReset
);

   ubg_pkg::ubg_top_state_t state;
   ubg_pkg::ubg_top_state_t next_state;
   ubg_timer_if tif ();

   logic accessStart;
   logic accessDone;

   function automatic logic regHit
   (
      input logic [11:0] addr,
      input logic [11:0] offset
   );
      regHit = (addr == offset);
   endfunction

   function automatic logic knownAddr
   (
      input logic [11:0] addr
   );
      knownAddr = regHit(addr, ubg_pkg::ADDR_CONTROL_TWO)
               || regHit(addr, ubg_pkg::ADDR_CONTROL_THREE)
               || regHit(addr, ubg_pkg::ADDR_DIVISOR)
               || regHit(addr, ubg_pkg::ADDR_STATUS);
   endfunction

   function automatic logic [31:0] readMux
   (
      input logic [11:0] addr,
      input ubg_pkg::ubg_top_state_t s,
      input logic [7:0] timerCount
   );
      logic [31:0] word;
      word = 32'h0000_0000;
      if (regHit(addr, ubg_pkg::ADDR_CONTROL_TWO))
      begin
         word[ubg_pkg::SPEED_SELECT_POS] = s.speedSel;
      end
      else if (regHit(addr, ubg_pkg::ADDR_CONTROL_THREE))
      begin
         // only the soft reset bit exists; the rest reads zero
         word[ubg_pkg::SOFT_RESET_POS] = s.ctrlReset; // RULE4
      end
      else if (regHit(addr, ubg_pkg::ADDR_DIVISOR))
      begin
         word[7:0] = s.divisor; // RULE9
      end
      else if (regHit(addr, ubg_pkg::ADDR_STATUS))
      begin
         word[7:0] = timerCount;
         word[ubg_pkg::STATUS_HOLD_POS] = s.portReset;
      end
      readMux = word;
   endfunction

   function automatic ubg_pkg::ubg_top_state_t resetState
   (
      input logic [7:0] keepDivisor
   );
      ubg_pkg::ubg_top_state_t s;
      s.ctrlReset = ubg_pkg::SOFT_RESET_RESET;
      s.speedSel = ubg_pkg::SPEED_SELECT_RESET;
      s.divisor = keepDivisor;
      s.prdata = 32'h0000_0000;
      s.pready = 1'b0;
      s.pslverr = 1'b0;
      s.bitTick = 1'b0;
      s.portReset = 1'b0;
      resetState = s;
   endfunction

   // first access cycle takes the request, the next one completes it
   assign accessStart = psel && penable && !state.pready;
   assign accessDone = psel && penable && state.pready;

   always_comb
   begin
      next_state = state;
      next_state.pready = 1'b0;
      next_state.pslverr = 1'b0;

      if (accessStart)
      begin
         next_state.pready = 1'b1;
         next_state.pslverr = !knownAddr(paddr);
         if (!pwrite)
         begin
            next_state.prdata = readMux(paddr, state, tif.count);
         end
         else
         begin
            next_state.prdata = 32'h0000_0000;
         end
      end

      if (accessDone && pwrite)
      begin
         if (regHit(paddr, ubg_pkg::ADDR_CONTROL_THREE))
         begin
            next_state.ctrlReset = pwdata[ubg_pkg::SOFT_RESET_POS]; // RULE4
         end
         // configuration is frozen while the port is held in reset
         if (!state.ctrlReset)
         begin
            if (regHit(paddr, ubg_pkg::ADDR_CONTROL_TWO))
            begin
               next_state.speedSel = pwdata[ubg_pkg::SPEED_SELECT_POS]; // RULE10
            end
            if (regHit(paddr, ubg_pkg::ADDR_DIVISOR))
            begin
               next_state.divisor = pwdata[7:0]; // RULE9 RULE8
            end
         end
      end

      if (state.ctrlReset)
      begin
         // hold speed select at its power-on value; divisor keeps its value
         next_state.speedSel = ubg_pkg::SPEED_SELECT_RESET; // RULE3 RULE2
      end

      next_state.portReset = state.ctrlReset; // RULE1 RULE2
      next_state.bitTick = tif.tick && !state.ctrlReset; // RULE11 RULE1
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= resetState(state.divisor); // RULE9
      end
      else
      begin
         state <= next_state;
      end
   end

   assign tif.divisor = state.divisor; // RULE6
   assign tif.speedSel = state.speedSel; // RULE6
   assign tif.hold = state.ctrlReset; // RULE2

   ubg_rate_timer timer_i
   (
      .clk(clk),
      .srst(srst),
      .tif(tif)
   );

   assign prdata = state.prdata;
   assign pready = state.pready;
   assign pslverr = state.pslverr;
   assign bitTick = state.bitTick;
   assign portReset = state.portReset;

endmodule

`default_nettype wire

// ### src/ubg_pkg_unused_guard.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ### bench/ubg_baud_core_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ubg_baud_core_asserts
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic bitTick,
   input wire logic portReset
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence sAcc;
      psel && penable && !pready;
   endsequence
   sequence sRd(a);
      psel && penable && pready && !pwrite && paddr == a;
   endsequence
   sequence sWr3(b);
      psel && penable && pready && pwrite
         && paddr == ubg_pkg::ADDR_CONTROL_THREE && pwdata[7] == b;
   endsequence
   AST_WAIT: assert property (sAcc |=> pready)
      else $error("no ready after access");
   AST_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than a cycle");
   AST_ERRREADY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_SET: assert property (sWr3(1'b1) |-> ##2 portReset)
      else $error("port reset not applied");
   AST_CLR: assert property (sWr3(1'b0) |-> ##2 !portReset)
      else $error("port reset not released");
   AST_NOTICK: assert property (portReset |-> !bitTick)
      else $error("tick while in reset");
   AST_SPACE: assert property (bitTick |=> !bitTick [*8] ##1 !bitTick [*7])
      else $error("ticks closer than 16 clocks");
   AST_RESTART: assert property ($fell(portReset) |-> !bitTick [*8])
      else $error("tick too soon after reset release");
   AST_LOWZERO: assert property (sRd(ubg_pkg::ADDR_CONTROL_THREE)
      |-> prdata[6:0] == 7'h0 && prdata[31:8] == 24'h0)
      else $error("unused control bits not zero");
   AST_SPEED: assert property (sRd(ubg_pkg::ADDR_CONTROL_TWO)
      ##0 portReset |-> !prdata[5])
      else $error("speed select not cleared in reset");
endmodule
bind ubg_baud_core ubg_baud_core_asserts u_chk (.clk, .srst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .bitTick, .portReset);
`default_nettype wire

// ### bench/tb_ubg_baud_core.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ubg_baud_core;
   localparam logic [11:0] C2 = ubg_pkg::ADDR_CONTROL_TWO;
   localparam logic [11:0] C3 = ubg_pkg::ADDR_CONTROL_THREE;
   localparam logic [11:0] DV = ubg_pkg::ADDR_DIVISOR;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, bitTick, portReset, err;
   logic [31:0] rnd = 32'h7fa0bd34;
   logic [7:0] n;
   int mismatches = 0;
   int testsRun = 0;
   int c;
   always #25 clk = ~clk;
   ubg_baud_core dut (.clk, .srst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .bitTick, .portReset);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int per(input logic sp, input logic [7:0] d);
      return (sp ? ubg_pkg::PRESCALE_HIGH : ubg_pkg::PRESCALE_LOW) * (d + 1);
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      chk(k, 32'd2);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // cycles up to the next tick
   task gap;
      c = 0;
      do
      begin
         @(negedge clk);
         c++;
      end
      while (bitTick !== 1'b1 && c < 5000);
   endtask
   task reportAndStop;
      $display("tests %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #4000000;
      mismatches++;
      reportAndStop;
   end
   initial
   begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      apb(1, DV, 32'h0);
      apb(0, C2, 0);
      chk(rd, 32'h0);
      chk(err, 1'b0);
      apb(1, C3, {rnd[31:8], 1'b0, rnd[6:0]});
      apb(0, C3, 0);
      chk(rd, 32'h0);
      apb(0, 12'h010, 0);
      chk({rd[30:0], err}, 32'h1);
      $display("register test done");
      for (int i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         n = (i == 0) ? 8'h00 : (i == 3) ? 8'hff : {5'h0, rnd[2:0]};
         apb(1, DV, {rnd[31:8], n});
         apb(0, DV, 0);
         chk(rd, {24'h0, n});
         apb(1, C2, 32'(i[0]) << 5);
         gap;
         gap;
         gap;
         chk(c, per(i[0], n));
      end
      $display("rate test done");
      apb(1, DV, 32'h2);
      apb(1, C3, 32'h80);
      apb(0, C3, 0);
      chk(rd, 32'h80);
      chk(portReset, 1);
      apb(1, C2, 32'h20);
      apb(0, C2, 0);
      chk(rd, 32'h0);
      apb(0, DV, 0);
      chk(rd, 32'h2);
      // status: hold flag set, timer parked on the divisor
      apb(0, 12'h00c, 0);
      chk(rd, {23'h0, 1'b1, 8'h02});
      c = 0;
      repeat (300) @(negedge clk) if (bitTick !== 1'b0) c++;
      chk(c, 0);
      apb(1, C3, 32'h0);
      gap;
      gap;
      chk(c, per(0, 8'h2));
      chk(portReset, 0);
      $display("soft reset test done");
      reportAndStop;
   end
endmodule
`default_nettype wire
